// ==== hdl/hotswap_fault_sequencer.sv ====
// hot-swap power sequencer with fault timers and register port
//
// Summary of operation
// - enable input good starts a 4.5 ms debounce before pass turn-on.
// - any bounce low during debounce restarts the debounce from zero.
// - turn-on uses 1.2A limit mode; each 2A trip re-engages that limit.
// - limiting continuously over 75 ms: pass off, 9 s wait, full restart.
// - short_timer runs from debounce end; no drain drop in 75 ms is fault.
// - overload enters limiting at once, 75 ms over-current timer faults.
// - over-current timer clears at once when the overload goes away.
// - after a trip, limiting is commanded within 10 us, held 100 us.
// - over-temperature turns pass off until temperature reset flag.
// - drain within 1V of supply: PWM the pass below 250 mA average.
// - power_good_n driven low only once gate is fully on.
// - after any fault, retry every 9 s forever unless thermal holds off.
//
// Implementation choices: the register addresses and strobed register access.
`include "hotswap_fault_sequencer_map.svh"

module hotswap_fault_sequencer
	import hotswap_fault_sequencer_pkg::*;
#(
	parameter int unsigned DEBOUNCE_CYC = `DEBOUNCE_CYC,
	parameter int unsigned SHORT_CYC = `SHORT_CYC,
	parameter int unsigned OVERCUR_CYC = `OVERCUR_CYC,
	parameter int unsigned RESTART_CYC = `RESTART_CYC,
	parameter int unsigned SETTLE_CYC = `SETTLE_CYC,
	parameter int unsigned PWM_PERIOD_CYC = `PWM_PERIOD_CYC,
	parameter int unsigned PWM_ON_CYC = `PWM_ON_CYC
) (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic i_lockout_enable_input,
	input wire logic i_over_limit,
	input wire logic i_breaker_trip_level,
	input wire logic i_drain_dropped,
	input wire logic i_drain_near_supply,
	input wire logic i_gate_full_on,
	input wire logic i_over_temp,
	input wire logic i_temp_reset,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	output logic o_irq,
	output logic o_pass_on,
	output logic o_limit_mode,
	output logic o_power_good_n,
	output logic o_power_good_n_oe
);

	localparam int LIM_RESP_MAX = 4;

	function automatic logic hits(input count_t c, input count_t lim);
		hits = (c >= lim - 28'd1);
	endfunction : hits

	// two-stage synchronisers for the comparator flags
	logic [7:0] pin_meta;
	logic [7:0] pin_sync;
	wire logic [7:0] pin_raw = {i_temp_reset, i_over_temp, i_gate_full_on,
		i_drain_near_supply, i_drain_dropped, i_breaker_trip_level,
		i_over_limit, i_lockout_enable_input};

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			pin_meta <= 8'h00;
			pin_sync <= 8'h00;
		end else begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
		end
	end

	wire logic uv_ok = pin_sync[0];
	wire logic over_s = pin_sync[1];
	wire logic trip_s = pin_sync[2];
	wire logic dropped_s = pin_sync[3];
	wire logic near_s = pin_sync[4];
	wire logic gate_s = pin_sync[5];
	wire logic hot_s = pin_sync[6];
	wire logic cool_s = pin_sync[7];

	seq_state_e state;
	seq_state_e next_state;
	count_t cnt;
	count_t next_cnt;
	count_t oc_cnt;
	count_t settle;
	count_t pwm_cnt;
	logic trip_d;
	logic uv_d;
	logic ev_short;
	logic ev_oc;
	logic [7:0] status;
	logic [7:0] mask;

	wire logic overload = over_s | trip_s;
	wire logic conducting = (state == ST_RAMP) || (state == ST_ON);
	wire logic oc_expired = overload && hits(oc_cnt, count_t'(OVERCUR_CYC));
	wire count_t next_oc = (overload && conducting) ?
		oc_cnt + 28'd1 : 28'd0;
	wire count_t next_pwm = hits(pwm_cnt, count_t'(PWM_PERIOD_CYC)) ?
		28'd0 : pwm_cnt + 28'd1;
	wire logic trip_rise = trip_s & ~trip_d;
	wire count_t next_settle = (trip_rise && state == ST_ON) ?
		count_t'(SETTLE_CYC) :
		(settle != 28'd0) ? settle - 28'd1 : 28'd0;

	// sequencer
	always_comb begin
		next_state = state;
		next_cnt = cnt + 28'd1;
		ev_short = 1'b0;
		ev_oc = 1'b0;
		case (state)
			ST_OFF: begin
				next_cnt = 28'd0;
				if (uv_ok) begin
					next_state = ST_DEBOUNCE;
				end
			end
			ST_DEBOUNCE: begin
				if (hits(cnt, count_t'(DEBOUNCE_CYC))) begin
					next_state = ST_RAMP;
					next_cnt = 28'd0;
				end
			end
			ST_RAMP: begin
				if (dropped_s) begin
					next_state = ST_ON;
					next_cnt = 28'd0;
				end else if (hits(cnt, count_t'(SHORT_CYC))) begin
					next_state = ST_RETRY;
					next_cnt = 28'd0;
					ev_short = 1'b1;
				end
				if (oc_expired) begin
					next_state = ST_RETRY;
					next_cnt = 28'd0;
					ev_oc = 1'b1;
				end
			end
			ST_ON: begin
				next_cnt = 28'd0;
				if (oc_expired) begin
					next_state = ST_RETRY;
					ev_oc = 1'b1;
				end
			end
			ST_RETRY: begin
				if (hits(cnt, count_t'(RESTART_CYC))) begin
					next_state = ST_OFF;
					next_cnt = 28'd0;
				end
			end
			ST_THERMAL: begin
				next_cnt = 28'd0;
				if (cool_s && !hot_s) begin
					next_state = ST_OFF;
				end
			end
			default: begin
				next_state = ST_OFF;
				next_cnt = 28'd0;
			end
		endcase
		// enable loss aborts turn-on; retry wait runs on regardless
		if (!uv_ok && state != ST_THERMAL && state != ST_RETRY) begin
			next_state = ST_OFF;
			next_cnt = 28'd0;
		end
		if (hot_s) begin
			next_state = ST_THERMAL;
			next_cnt = 28'd0;
		end
	end

	// drive decisions
	wire logic pwm_cut = near_s && (pwm_cnt >= count_t'(PWM_ON_CYC));
	wire logic next_pass = (next_state == ST_RAMP || next_state == ST_ON)
		&& conducting && !pwm_cut;
	wire logic next_limit = (state == ST_RAMP) || (state == ST_ON &&
		(overload || settle != 28'd0));
	wire logic next_pg_oe = (state == ST_ON) && (next_state == ST_ON) &&
		gate_s;

	// interrupt events
	wire logic [7:0] events = {2'b00,
		uv_d & ~uv_ok,
		next_pg_oe & ~o_power_good_n_oe,
		trip_rise & conducting,
		(next_state == ST_THERMAL) && (state != ST_THERMAL),
		ev_oc,
		ev_short};
	wire logic [7:0] clear = (i_wr && i_addr == `REG_STATUS) ?
		i_wdata : 8'h00;
	wire logic [7:0] next_status = (status & ~clear) | events;
	wire logic [7:0] state_view = {1'b0, o_power_good_n_oe,
		6'(state)};
	wire logic [7:0] read_mux =
		(i_addr == `REG_STATUS) ? status :
		(i_addr == `REG_MASK) ? mask :
		(i_addr == `REG_STATE) ? state_view : 8'h00;

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			state <= ST_OFF;
			cnt <= 28'd0;
			oc_cnt <= 28'd0;
			settle <= 28'd0;
			pwm_cnt <= 28'd0;
			trip_d <= 1'b0;
			uv_d <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			oc_cnt <= next_oc;
			settle <= next_settle;
			pwm_cnt <= next_pwm;
			trip_d <= trip_s;
			uv_d <= uv_ok;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_pass_on <= 1'b0;
			o_limit_mode <= 1'b0;
			o_power_good_n <= 1'b0;
			o_power_good_n_oe <= 1'b0;
		end else begin
			o_pass_on <= next_pass;
			o_limit_mode <= next_limit;
			o_power_good_n <= 1'b0;
			o_power_good_n_oe <= next_pg_oe;
		end
	end

	// register port; set wins over a write-one clear
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			status <= `STATUS_RESET;
			mask <= `MASK_RESET;
			o_irq <= 1'b0;
			o_rdata <= 8'h00;
		end else begin
			status <= next_status;
			if (i_wr && i_addr == `REG_MASK) begin
				mask <= i_wdata;
			end
			o_irq <= |(next_status & mask);
			o_rdata <= i_rd ? read_mux : 8'h00;
		end
	end

	// checks
	AST_DEBOUNCE_END: assert property (
		@(posedge i_clk_sys) disable iff (i_reset)
		state == ST_DEBOUNCE && uv_ok && !hot_s &&
		cnt == count_t'(DEBOUNCE_CYC - 1) |=> state == ST_RAMP)
		else $error("debounce did not end on time");

	AST_BOUNCE: assert property (
		@(posedge i_clk_sys) disable iff (i_reset)
		state == ST_DEBOUNCE && !uv_ok && !hot_s |=>
		state == ST_OFF && cnt == 28'd0)
		else $error("bounce did not restart debounce");

	AST_RAMP_LIMIT: assert property (
		@(posedge i_clk_sys) disable iff (i_reset)
		state == ST_RAMP |=> o_limit_mode)
		else $error("limit mode missing during turn-on");

	AST_LIMIT_TIMEOUT: assert property (
		@(posedge i_clk_sys) disable iff (i_reset)
		state == ST_RAMP && overload && uv_ok && !hot_s &&
		oc_cnt == count_t'(OVERCUR_CYC - 1) |=> state == ST_RETRY ##1 !o_pass_on)
		else $error("limit timeout did not shut pass off");

	AST_SHORT_FAULT: assert property (
		@(posedge i_clk_sys) disable iff (i_reset)
		state == ST_RAMP && !dropped_s && uv_ok && !hot_s &&
		cnt == count_t'(SHORT_CYC - 1) |=> state == ST_RETRY && status[`EV_SHORT])
		else $error("short fault not declared");

	AST_OC_FAULT: assert property (
		@(posedge i_clk_sys) disable iff (i_reset)
		state == ST_ON && overload && uv_ok && !hot_s &&
		oc_cnt == count_t'(OVERCUR_CYC - 1) |=> state == ST_RETRY &&
		status[`EV_OVERCUR])
		else $error("over-current fault not declared");

	AST_OC_CLEAR: assert property (
		@(posedge i_clk_sys) disable iff (i_reset)
		!overload |=> oc_cnt == 28'd0)
		else $error("over-current timer not cleared");

	AST_TRIP_LIMIT: assert property (
		@(posedge i_clk_sys) disable iff (i_reset)
		$rose(trip_s) && state == ST_ON && uv_ok && !hot_s |->
		##[1:LIM_RESP_MAX] o_limit_mode)
		else $error("trip did not engage limiting");

	AST_SETTLE_HOLD: assert property (
		@(posedge i_clk_sys) disable iff (i_reset)
		state == ST_ON && settle != 28'd0 |=> o_limit_mode)
		else $error("limit dropped before settle time");

	AST_THERMAL_OFF: assert property (
		@(posedge i_clk_sys) disable iff (i_reset)
		hot_s |=> state == ST_THERMAL ##1 !o_pass_on)
		else $error("pass not off on over-temperature");

	AST_PWM_CUT: assert property (
		@(posedge i_clk_sys) disable iff (i_reset)
		near_s && pwm_cnt >= count_t'(PWM_ON_CYC) |=> !o_pass_on)
		else $error("pass on outside pwm window");

	AST_PGOOD: assert property (
		@(posedge i_clk_sys) disable iff (i_reset)
		o_power_good_n_oe |-> $past(gate_s) && !o_power_good_n)
		else $error("power good without full gate");

	AST_PG_RELEASE: assert property (
		@(posedge i_clk_sys) disable iff (i_reset)
		state != ST_ON |=> !o_power_good_n_oe)
		else $error("power good held outside on state");

	AST_RETRY: assert property (
		@(posedge i_clk_sys) disable iff (i_reset)
		state == ST_RETRY && !hot_s &&
		cnt == count_t'(RESTART_CYC - 1) |=> state == ST_OFF)
		else $error("retry did not restart");

	AST_RESET_OFF: assert property (
		@(posedge i_clk_sys)
		i_reset |=> state == ST_OFF && !o_power_good_n_oe && !o_pass_on)
		else $error("reset did not give off state");

	AST_ENABLE_DROP: assert property (
		@(posedge i_clk_sys) disable iff (i_reset)
		!uv_ok && !hot_s && state != ST_THERMAL && state != ST_RETRY |=>
		state == ST_OFF ##1 !o_pass_on && !o_power_good_n_oe)
		else $error("enable drop did not switch off");

endmodule : hotswap_fault_sequencer

// ==== hdl/hotswap_fault_sequencer_map.svh ====
// offsets, field positions, reset values and timing figures of the sequencer
`ifndef HOTSWAP_FAULT_SEQUENCER_MAP_SVH
`define HOTSWAP_FAULT_SEQUENCER_MAP_SVH

// reference clock in kHz
`define CLK_KHZ 20000

// times in their own units
`define DEBOUNCE_US 4500
`define SHORT_MS 75
`define OVERCUR_MS 75
`define RESTART_MS 9000
`define LIMIT_RESP_US 10
`define SETTLE_US 100
`define PWM_PERIOD_US 10
`define PWM_ON_PCT 20

// cycle counts derived from the times
`define DEBOUNCE_CYC ((`DEBOUNCE_US * `CLK_KHZ + 999) / 1000)
`define SHORT_CYC (`SHORT_MS * `CLK_KHZ)
`define OVERCUR_CYC (`OVERCUR_MS * `CLK_KHZ)
`define RESTART_CYC (`RESTART_MS * `CLK_KHZ)
`define LIMIT_RESP_CYC ((`LIMIT_RESP_US * `CLK_KHZ) / 1000)
`define SETTLE_CYC ((`SETTLE_US * `CLK_KHZ + 999) / 1000)
`define PWM_PERIOD_CYC ((`PWM_PERIOD_US * `CLK_KHZ) / 1000)
`define PWM_ON_CYC ((`PWM_PERIOD_CYC * `PWM_ON_PCT) / 100)

// register offsets
`define REG_STATUS 4'h0
`define REG_MASK 4'h1
`define REG_STATE 4'h2

// event bit positions in status and mask
`define EV_SHORT 0
`define EV_OVERCUR 1
`define EV_THERMAL 2
`define EV_TRIP 3
`define EV_PGOOD 4
`define EV_LOCKOUT 5

// reset values
`define MASK_RESET 8'h00
`define STATUS_RESET 8'h00

`endif

// ==== hdl/hotswap_fault_sequencer_pkg.sv ====
// types of the hot-swap fault sequencer
package hotswap_fault_sequencer_pkg;

	typedef enum logic [5:0] {
		ST_OFF = 6'h01,
		ST_DEBOUNCE = 6'h02,
		ST_RAMP = 6'h04,
		ST_ON = 6'h08,
		ST_RETRY = 6'h10,
		ST_THERMAL = 6'h20
	} seq_state_e;

	typedef logic [27:0] count_t;

endpackage : hotswap_fault_sequencer_pkg

// ==== tb/load_partner.sv ====
// load capacitance and converter seen from the pass element
module load_partner (
	input wire logic i_clk_sys,
	input wire logic i_pass_on,
	input wire logic i_shorted,
	input wire logic [7:0] i_charge_cyc,
	output logic o_drain_dropped,
	output logic o_drain_near_supply,
	output logic o_gate_full_on
);
	timeunit 1ns;
	timeprecision 1ns;
	int charge = 0;
	int idle = 0;
	// charge held through short pwm gaps, lost on long off
	always @(posedge i_clk_sys) begin
		idle <= i_pass_on ? 0 : idle + 1;
		if (idle > 12)
			charge <= 0;
		else if (i_pass_on)
			charge <= charge + 1;
	end
	assign o_drain_dropped = !i_shorted && charge >= int'(i_charge_cyc);
	assign o_drain_near_supply = i_shorted;
	assign o_gate_full_on = o_drain_dropped && charge >= i_charge_cyc + 2;
endmodule : load_partner

// ==== tb/tb_top.sv ====
// self-checking bench of the hot-swap fault sequencer
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DEB = 20;
	localparam int SHORT = 60;
	localparam int OVC = 40;
	localparam int RST = 100;
	localparam int SETTLE = 10;
	logic clk = 0, rst = 1, en = 0, ovl = 0, trip = 0, otemp = 0;
	logic treset = 1, wr = 0, rd = 0, shorted = 0;
	logic ddrop, dnear, gfull, irq, pass, lim, pgn, pgoe;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00, chg = 8'h08, rdata;
	int fails = 0, checks_done = 0, n;
	always #25 clk = ~clk;
	hotswap_fault_sequencer #(.DEBOUNCE_CYC(DEB), .SHORT_CYC(SHORT),
		.OVERCUR_CYC(OVC), .RESTART_CYC(RST), .SETTLE_CYC(SETTLE),
		.PWM_PERIOD_CYC(10), .PWM_ON_CYC(2)) u_hotswap_fault_sequencer (
		.i_clk_sys(clk), .i_reset(rst), .i_lockout_enable_input(en),
		.i_over_limit(ovl), .i_breaker_trip_level(trip),
		.i_drain_dropped(ddrop), .i_drain_near_supply(dnear),
		.i_gate_full_on(gfull), .i_over_temp(otemp), .i_temp_reset(treset),
		.i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdata), .o_irq(irq), .o_pass_on(pass), .o_limit_mode(lim),
		.o_power_good_n(pgn), .o_power_good_n_oe(pgoe));
	load_partner u_load_partner (.i_clk_sys(clk), .i_pass_on(pass),
		.i_shorted(shorted), .i_charge_cyc(chg), .o_drain_dropped(ddrop),
		.o_drain_near_supply(dnear), .o_gate_full_on(gfull));
	task automatic wrap_up();
		$display("checks %0d errors %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: %h %h", $time, got, exp);
		end
	endtask : chk
	task automatic step(input int k);
		repeat (k) @(posedge clk);
	endtask : step
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask : rd_reg
	task automatic status(input logic [7:0] exp);
		rd_reg(4'h0, exp);
		wr_reg(4'h0, 8'hff);
	endtask : status
	function automatic logic sig(input int s);
		case (s)
			0: return pass;
			1: return lim;
			default: return pgoe;
		endcase
	endfunction : sig
	// bounded wait, n counts the edges taken
	task automatic wait_sig(input int s, input logic v, input int bound);
		n = 0;
		while (sig(s) !== v) begin
			@(posedge clk);
			n++;
			if (n > bound) begin
				chk({7'h0, sig(s)}, {7'h0, v});
				wrap_up();
			end
		end
	endtask : wait_sig
	initial begin
		void'($urandom(96));
		chg <= 8'($urandom_range(12, 5));
		step(16);
		rst <= 1'b0;
		chk({4'h0, pass, lim, pgoe, irq}, 8'h00);
		rd_reg(4'h2, 8'h01);
		rd_reg(4'h1, 8'h00);
		rd_reg(4'hf, 8'h00);
		wr_reg(4'h1, 8'h10);
		en <= 1'b1;
		step($urandom_range(15, 5));
		en <= 1'b0;
		step(4);
		en <= 1'b1;
		wait_sig(0, 1'b1, DEB + 20);
		chk(8'(n >= DEB), 8'h01);
		chk(8'(n <= DEB + 6), 8'h01);
		chk({7'h0, lim}, 8'h01);
		wr_reg(4'h0, 8'hff);
		wait_sig(2, 1'b1, 40);
		chk({6'h0, gfull, pgn}, 8'h02);
		chk({7'h0, lim}, 8'h00);
		step(2);
		chk({7'h0, irq}, 8'h01);
		status(8'h10);
		step(2);
		chk({7'h0, irq}, 8'h00);
		rd_reg(4'h2, 8'h48);
		step(1);
		trip <= 1'b1;
		step(2);
		trip <= 1'b0;
		wait_sig(1, 1'b1, 6);
		wait_sig(1, 1'b0, SETTLE + 10);
		chk(8'(n >= SETTLE - 2), 8'h01);
		chk({7'h0, irq}, 8'h00);
		status(8'h08);
		for (int k = 0; k < 2; k++) begin
			ovl <= 1'b1;
			step(6);
			chk({7'h0, lim}, 8'h01);
			step(OVC - 14);
			ovl <= 1'b0;
			step(4);
		end
		chk({7'h0, pass}, 8'h01);
		ovl <= 1'b1;
		wait_sig(0, 1'b0, OVC + 10);
		chk(8'(n >= OVC - 2), 8'h01);
		ovl <= 1'b0;
		rd_reg(4'h2, 8'h10);
		wait_sig(0, 1'b1, RST + DEB + 20);
		chk(8'(n >= RST + DEB - 6), 8'h01);
		wait_sig(2, 1'b1, 40);
		status(8'h12);
		otemp <= 1'b1;
		wait_sig(0, 1'b0, 6);
		otemp <= 1'b0;
		treset <= 1'b0;
		step(10);
		chk({7'h0, pass}, 8'h00);
		rd_reg(4'h2, 8'h20);
		step(1);
		treset <= 1'b1;
		step(6);
		rd_reg(4'h2, 8'h02);
		wait_sig(2, 1'b1, DEB + 40);
		status(8'h14);
		en <= 1'b0;
		wait_sig(0, 1'b0, 6);
		chk({7'h0, pgoe}, 8'h00);
		step(4);
		rd_reg(4'h2, 8'h01);
		status(8'h20);
		shorted <= 1'b1;
		en <= 1'b1;
		wait_sig(0, 1'b1, DEB + 20);
		step(5);
		n = 0;
		repeat (40) begin
			@(posedge clk);
			n += int'(pass);
		end
		chk(8'(n), 8'd8);
		step(SHORT - 30);
		rd_reg(4'h2, 8'h10);
		status(8'h01);
		// overload held through the next turn-on: limit timeout in ramp
		ovl <= 1'b1;
		wait_sig(0, 1'b1, RST + DEB + 20);
		step(OVC + 10);
		chk({7'h0, pass}, 8'h00);
		rd_reg(4'h2, 8'h10);
		status(8'h02);
		wrap_up();
	end
endmodule : tb_top
